// ===== hw/pmpc_top.v
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pmpc_defines.vh"
// Overview of operation
// - Permission register writable once per system reset
// - Refused mode requests keep the present mode
// - Permission register cleared by chip reset
// - Bit 5 permits very-low-power run/wait/stop
// - Bit 3 permits low-leakage stop
// - Bit 1 permits all very-low-leakage submodes
// - Reserved bits read zero, not writable
// - Request register cleared by power-on reset, stop-mode field also by first permission write
// - Run-mode field bits 6-5 requests run mode
// - Run-mode writes blocked without matching permission
// - Run-mode field cleared on exit to run
// - Abort flag shows previous stop entry aborted
// - Abort flag cleared at entry, set on abort
// - Stop-mode field bits 2-0 selects stop mode
// - One-hot read-only status shows current mode
// - User-mode writes blocked with bus error
module pmpc_top (
    // Clock, enable and resets
    input  wire        clk_sys,
    input  wire        clk_en,
    input  wire        arst_n,
    input  wire        chip_rst_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [3:0]  hprot,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Sequencer handshake (same clock domain)
    input  wire        stop_entry_start,
    input  wire        stop_entry_abort,
    input  wire        stop_entry_done,
    input  wire        run_mode_reached,
    input  wire        wake_to_run,
    input  wire        wait_entry,
    // Mode outputs
    output reg  [7:0]  power_mode_status,
    output reg  [1:0]  run_mode_select,
    output reg  [2:0]  stop_mode_select,
    output reg         stop_permitted
);

    // Bus phase states; the two error states give the two-cycle
    // error response of the AHB-Lite bus
    localparam ST_IDLE = 2'b00;
    localparam ST_ERR1 = 2'b01;
    localparam ST_ERR2 = 2'b10;

    // Permission register and write-once lock
    reg  [7:0] perm_r;                 // Permission bits
    reg        perm_lock_r;            // Set after first write
    // Request register fields
    reg  [1:0] run_mode_select_r;                 // Run-mode request
    reg  [2:0] stop_mode_select_r;                // Stop-mode request
    reg        abort_r;                // Stop abort flag
    reg  [7:0] stat_r;                 // One-hot current mode
    // Bus pipeline
    reg  [1:0] state_r;                // Error response sequencer
    reg        wr_pend_r;              // Write data phase pending
    reg  [7:0] wr_addr_r;              // Latched write address
    // Reset-request synchroniser for the chip reset pin
    reg  [1:0] chip_sync_r;            // Two-flop synchroniser

    // Address phase decode; only NONSEQ is a real transfer, so IDLE
    // and BUSY cycles neither read nor write anything
    wire       xfer     = hsel & hready & (htrans == `PMPC_HTRANS_NONSEQ);
    // Privileged accesses carry hprot bit 1 set
    wire       priv     = hprot[1];
    // User writes are refused; privileged writes open a data phase
    wire       user_wr  = xfer & hwrite & ~priv;
    wire       good_wr  = xfer & hwrite & priv;
    // Data phase strobes, one per writable register
    wire       wr_perm  = wr_pend_r & (wr_addr_r == `PMPC_OFF_PERMIT);
    wire       wr_req   = wr_pend_r & (wr_addr_r == `PMPC_OFF_REQUEST);
    // Chip reset request, read only from the second stage
    wire       chip_ok  = chip_sync_r[1];

    // Requested field values from the write data; taken in the data
    // phase, never from the address phase
    wire [1:0] run_mode_select_w   = hwdata[`PMPC_RUN_MODE_SELECT_HI:`PMPC_RUN_MODE_SELECT_LO];
    wire [2:0] stop_mode_select_w  = hwdata[`PMPC_STOP_MODE_SELECT_HI:`PMPC_STOP_MODE_SELECT_LO];

    // Permission check for a run request
    reg        run_mode_select_ok;
    always @* begin
        // Reserved codes fall through and stay refused
        run_mode_select_ok = 1'b0;
        // Normal run is always allowed
        if (run_mode_select_w == `PMPC_RUN_NORMAL) begin
            run_mode_select_ok = 1'b1;
        end else if (run_mode_select_w == `PMPC_RUN_VLP) begin
            run_mode_select_ok = perm_r[`PMPC_BIT_VLP];
        end
    end

    // Permission check for a stop selection
    reg        stop_mode_select_ok;
    always @* begin
        // Reserved stop codes fall through and stay refused
        stop_mode_select_ok = 1'b0;
        if (stop_mode_select_w == `PMPC_STOP_NORMAL) begin
            stop_mode_select_ok = 1'b1;
        end else if (stop_mode_select_w == `PMPC_STOP_VLP) begin
            stop_mode_select_ok = perm_r[`PMPC_BIT_VLP];
        end else if (stop_mode_select_w == `PMPC_STOP_LLS) begin
            stop_mode_select_ok = perm_r[`PMPC_BIT_LLS];
        end else if (stop_mode_select_w == `PMPC_STOP_VLLS) begin
            stop_mode_select_ok = perm_r[`PMPC_BIT_VLLS];
        end
    end

    // Permission check for the stop code already held; a chip reset may
    // clear permission while the request register keeps a low-power code
    reg        stop_mode_select_cur_ok;
    always @* begin
        stop_mode_select_cur_ok = 1'b0;
        if (stop_mode_select_r == `PMPC_STOP_NORMAL) begin
            stop_mode_select_cur_ok = 1'b1;
        end else if (stop_mode_select_r == `PMPC_STOP_VLP) begin
            stop_mode_select_cur_ok = perm_r[`PMPC_BIT_VLP];
        end else if (stop_mode_select_r == `PMPC_STOP_LLS) begin
            stop_mode_select_cur_ok = perm_r[`PMPC_BIT_LLS];
        end else if (stop_mode_select_r == `PMPC_STOP_VLLS) begin
            stop_mode_select_cur_ok = perm_r[`PMPC_BIT_VLLS];
        end
    end

    // Read data mux, decoded in the address phase
    reg  [7:0] rd_byte;
    always @* begin
        // Unmapped offsets read zero
        rd_byte = 8'h00;
        if (haddr == `PMPC_OFF_PERMIT) begin
            rd_byte = perm_r & `PMPC_PERMIT_MASK;
        end else if (haddr == `PMPC_OFF_REQUEST) begin
            rd_byte = {1'b0, run_mode_select_r, 1'b0, abort_r, stop_mode_select_r};
        end else if (haddr == `PMPC_OFF_STATUS) begin
            rd_byte = stat_r;
        end
    end

    // Chip reset pin synchroniser; both stages start low, so the
    // permission register is also cleared after power-on
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chip_sync_r <= 2'b00;
        end else if (clk_en) begin
            chip_sync_r <= {chip_sync_r[0], chip_rst_n};
        end
    end

    // Permission register: cleared on power-on and chip reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            perm_r      <= 8'h00;
            perm_lock_r <= 1'b0;
        end else if (clk_en) begin
            // Chip reset request clears permission and reopens the lock
            if (!chip_ok) begin
                perm_r      <= 8'h00;
                perm_lock_r <= 1'b0;
            end else if (wr_perm && !perm_lock_r) begin
                // First write only; later ones still answer OKAY
                // but change nothing until the next chip reset
                perm_r      <= hwdata[7:0] & `PMPC_PERMIT_MASK;
                perm_lock_r <= 1'b1;
            end
        end
    end

    // Request register and mode status: power-on reset only
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            run_mode_select_r  <= `PMPC_RUN_NORMAL;
            stop_mode_select_r <= `PMPC_STOP_NORMAL;
            abort_r <= 1'b0;
            stat_r  <= `PMPC_STAT_RUN;
        end else if (clk_en) begin
            // Run-mode field; exit to run wins over a request
            // written in the same cycle
            if (wake_to_run) begin
                run_mode_select_r <= `PMPC_RUN_NORMAL;
            end else if (wr_req && run_mode_select_ok) begin
                run_mode_select_r <= run_mode_select_w;
            end
            // Stop-mode field; reserved codes leave it as is
            // A first permission write clears the field
            if (wr_perm && !perm_lock_r) begin
                stop_mode_select_r <= `PMPC_STOP_NORMAL;
            end else if (wr_req && stop_mode_select_ok) begin
                stop_mode_select_r <= stop_mode_select_w;
            end
            // Abort flag: abort (set) wins over entry start (clear)
            // Both pulses come from the sequencer on this clock
            if (stop_entry_abort) begin
                abort_r <= 1'b1;
            end else if (stop_entry_start) begin
                abort_r <= 1'b0;
            end
            // One-hot mode tracking
            // Exit to run overrides every other event
            if (wake_to_run) begin
                stat_r <= `PMPC_STAT_RUN;
            end else if (stop_entry_done) begin
                // Permission may be lost since the code was written;
                // a refused entry leaves the mode as it is
                if (!stop_mode_select_cur_ok) begin
                    stat_r <= stat_r;
                end else if (stop_mode_select_r == `PMPC_STOP_VLP) begin
                    stat_r <= `PMPC_STAT_VERY_LOW_POWER_STOP;
                end else if (stop_mode_select_r == `PMPC_STOP_LLS) begin
                    stat_r <= `PMPC_STAT_LLS;
                end else if (stop_mode_select_r == `PMPC_STOP_VLLS) begin
                    stat_r <= `PMPC_STAT_VLLS;
                end else begin
                    stat_r <= `PMPC_STAT_STOP;
                end
            end else if (wait_entry && stat_r == `PMPC_STAT_VERY_LOW_POWER_RUN) begin
                // Wait is entered only from low-power run
                stat_r <= `PMPC_STAT_VERY_LOW_POWER_WAIT;
            end else if (run_mode_reached) begin
                // Sequencer reports arrival at requested run mode; a
                // low-power code held without permission counts as run
                if (run_mode_select_r == `PMPC_RUN_VLP && perm_r[`PMPC_BIT_VLP]) begin
                    stat_r <= `PMPC_STAT_VERY_LOW_POWER_RUN;
                end else begin
                    stat_r <= `PMPC_STAT_RUN;
                end
            end
        end
    end

    // AHB-Lite slave: zero-wait reads, one-cycle write commit
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= ST_IDLE;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= `PMPC_HRESP_OKAY;
        end else if (clk_en) begin
            // Write strobe lasts one data phase only
            wr_pend_r <= 1'b0;
            case (state_r)
                // Last error cycle also takes the next address phase, so a
                // pipelined master loses no transfer after an error
                ST_IDLE, ST_ERR2: begin
                    state_r   <= ST_IDLE;
                    hresp     <= `PMPC_HRESP_OKAY;
                    hreadyout <= 1'b1;
                    if (user_wr) begin
                        // First error cycle: not ready
                        state_r   <= ST_ERR1;
                        hreadyout <= 1'b0;
                        hresp     <= `PMPC_HRESP_ERROR;
                    end else if (good_wr) begin
                        // Commit waits for hwdata in the data phase
                        wr_pend_r <= 1'b1;
                        wr_addr_r <= haddr;
                    end else if (xfer) begin
                        // Reads answer with zero wait states
                        hrdata <= {24'h00_0000, rd_byte};
                    end
                end
                ST_ERR1: begin
                    // Second error cycle: ready
                    state_r   <= ST_ERR2;
                    hreadyout <= 1'b1;
                end
                // Unused code returns to idle
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Mode outputs toward the sequencer
    // Registered copies keep every top output straight from a flip-flop
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_mode_status <= `PMPC_STAT_RUN;
            run_mode_select   <= `PMPC_RUN_NORMAL;
            stop_mode_select  <= `PMPC_STOP_NORMAL;
            stop_permitted    <= 1'b1;
        end else if (clk_en) begin
            power_mode_status <= stat_r;
            run_mode_select   <= run_mode_select_r;
            stop_mode_select  <= stop_mode_select_r;
            stop_permitted    <= stop_mode_select_cur_ok;
        end
    end

endmodule

// ===== include/pmpc_defines.vh
`ifndef PMPC_DEFINES_VH
`define PMPC_DEFINES_VH

// Register byte offsets (word aligned)
`define PMPC_OFF_PERMIT     8'h00
`define PMPC_OFF_REQUEST    8'h04
`define PMPC_OFF_STATUS     8'h08
`define PMPC_OFF_EVENT      8'h0C

// Permission register fields
`define PMPC_BIT_VLP        5
`define PMPC_BIT_LLS        3
`define PMPC_BIT_VLLS       1
`define PMPC_PERMIT_MASK    8'h2A

// Request register fields
`define PMPC_RUN_MODE_SELECT_HI        6
`define PMPC_RUN_MODE_SELECT_LO        5
`define PMPC_BIT_ABORT      3
`define PMPC_STOP_MODE_SELECT_HI       2
`define PMPC_STOP_MODE_SELECT_LO       0

// Run mode encodings
`define PMPC_RUN_NORMAL     2'h0
`define PMPC_RUN_VLP        2'h2

// Stop mode encodings
`define PMPC_STOP_NORMAL    3'h0
`define PMPC_STOP_VLP       3'h2
`define PMPC_STOP_LLS       3'h3
`define PMPC_STOP_VLLS      3'h4

// One-hot status codes
`define PMPC_STAT_RUN       8'h01
`define PMPC_STAT_STOP      8'h02
`define PMPC_STAT_VERY_LOW_POWER_RUN      8'h04
`define PMPC_STAT_VERY_LOW_POWER_WAIT      8'h08
`define PMPC_STAT_VERY_LOW_POWER_STOP      8'h10
`define PMPC_STAT_LLS       8'h20
`define PMPC_STAT_VLLS      8'h40

// AHB codes
`define PMPC_HTRANS_NONSEQ  2'h2
`define PMPC_HRESP_OKAY     1'b0
`define PMPC_HRESP_ERROR    1'b1

`endif

// ===== testbench/pmpc_top_props.sv
`timescale 1ns/1ps
module pmpc_props (
    // Clock and resets
    input wire        clk_sys,
    input wire        arst_n,
    input wire        clk_en,
    // Bus side
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [3:0]  hprot,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // Mode side
    input wire        wake_to_run,
    input wire [7:0]  power_mode_status,
    input wire [1:0]  run_mode_select,
    input wire [2:0]  stop_mode_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Address phase taken this edge
    wire take_w = hsel && hready && htrans == 2'h2 && clk_en;
    upper_zero_a: assert property (
        hrdata[31:8] == 24'h0) else $error("upper read bits set");
    perm_rsvd_a: assert property (
        take_w && !hwrite && haddr == 8'h00 |=> (hrdata & 32'hD5) == 32'h0)
        else $error("permission reserved bits set");
    run_mode_select_legal_a: assert property (
        !run_mode_select[0]) else $error("reserved run mode shown");
    stop_mode_select_legal_a: assert property (
        stop_mode_select inside {3'h0, 3'h2, 3'h3, 3'h4}) else $error("reserved stop mode");
    onehot_stat_a: assert property (
        $onehot(power_mode_status)) else $error("status not one-hot");
    wake_run_a: assert property (
        wake_to_run && clk_en |-> ##[1:3] run_mode_select == 2'h0 && power_mode_status == 8'h01)
        else $error("exit to run left mode");
    user_err_a: assert property (
        take_w && hwrite && !hprot[1] |=> !hreadyout && hresp ##1 hreadyout && hresp)
        else $error("user write not refused");
    priv_ok_a: assert property (
        take_w && hwrite && hprot[1] |=> hreadyout && !hresp) else $error("privileged write error");
    reset_vals_a: assert property (
        $rose(arst_n) |-> power_mode_status == 8'h01 && run_mode_select == 2'h0
        && stop_mode_select == 3'h0 && hreadyout) else $error("bad reset values");
endmodule
bind pmpc_top pmpc_props u_pmpc_props (.clk_sys, .arst_n, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hprot, .hready, .hrdata, .hreadyout, .hresp, .wake_to_run, .power_mode_status,
    .run_mode_select, .stop_mode_select);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    // Clock, resets and bus
    logic        clk_sys = 0;
    logic        arst_n = 0;
    logic        chip_rst_n = 1;
    logic        clk_en = 1;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [3:0]  hprot = 4'h3;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // Events: start, abort, done, reached, wake, wait
    logic [5:0]  ev = 6'h00;
    logic [7:0]  power_mode_status;
    logic [1:0]  run_mode_select;
    logic [2:0]  stop_mode_select;
    logic [31:0] rdv;
    logic        rsp;
    logic        stop_permitted;
    int          errors = 0;
    int          comparisons = 0;

    pmpc_top u_pmpc_top (.clk_sys(clk_sys), .clk_en(clk_en), .arst_n(arst_n),
        .chip_rst_n(chip_rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_entry_start(ev[0]),
        .stop_entry_abort(ev[1]), .stop_entry_done(ev[2]), .run_mode_reached(ev[3]),
        .wake_to_run(ev[4]), .wait_entry(ev[5]), .power_mode_status(power_mode_status),
        .run_mode_select(run_mode_select), .stop_mode_select(stop_mode_select),
        .stop_permitted(stop_permitted));

    // Free running 50 MHz clock
    initial forever #10 clk_sys = ~clk_sys;

    // Single transfer; writes get one idle edge so a read sees the update
    task bus(input logic w, input logic [3:0] p, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hprot <= p;
        haddr <= a;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rdv = hrdata;
        rsp = hresp;
        if (w) @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 4'h3, a, d);
    endtask
    // Read, then compare against the expected word
    task rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, 4'h3, a, 32'h0);
        chk(rdv, e);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One-cycle event pulse, then let registered copies settle
    task pulse(input logic [5:0] m);
        ev <= m;
        @(posedge clk_sys);
        ev <= 6'h00;
        repeat (2) @(posedge clk_sys);
    endtask

    // Values straight after power-on reset
    task t_reset;
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0);
        rc(8'h08, 32'h1);
        wr(8'h08, 32'hFF);
        rc(8'h08, 32'h1);
        rc(8'h0C, 32'h0);
    endtask
    // Low-power requests while nothing is permitted
    task t_refuse;
        logic [7:0] bad [3] = '{8'h42, 8'h03, 8'h04};
        foreach (bad[i]) begin
            wr(8'h04, {24'h0, bad[i]});
            rc(8'h04, 32'h0);
        end
    endtask
    // Permission sticks after the first write only
    task t_permit;
        wr(8'h00, 32'hFF);
        rc(8'h00, 32'h2A);
        wr(8'h00, 32'h00);
        rc(8'h00, 32'h2A);
    endtask
    // Run mode change, wait and exit
    task t_run;
        wr(8'h04, 32'hF0);
        rc(8'h04, 32'h0);
        wr(8'h04, 32'h40);
        rc(8'h04, 32'h40);
        chk(run_mode_select, 32'h2);
        pulse(6'h08);
        chk(power_mode_status, 32'h04);
        wr(8'h04, 32'h00);
        pulse(6'h08);
        chk(power_mode_status, 32'h01);
        wr(8'h04, 32'h40);
        pulse(6'h08);
        rc(8'h08, 32'h04);
        pulse(6'h20);
        chk(power_mode_status, 32'h08);
        pulse(6'h10);
        chk(power_mode_status, 32'h01);
        rc(8'h04, 32'h0);
    endtask
    // Each defined stop code, then reserved code 1 last
    task t_stop;
        logic [2:0] sm [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h1};
        foreach (sm[i]) begin
            wr(8'h04, {29'h0, sm[i]});
            rc(8'h04, (sm[i] == 3'h1) ? 32'h4 : {29'h0, sm[i]});
            chk(stop_permitted, 32'h1);
        end
        pulse(6'h04);
        chk(power_mode_status, 32'h40);
        pulse(6'h10);
    endtask
    // Abort flag set, cleared, and abort winning over start
    task t_abort;
        pulse(6'h01);
        pulse(6'h02);
        rc(8'h04, 32'h0C);
        pulse(6'h01);
        rc(8'h04, 32'h04);
        pulse(6'h03);
        rc(8'h04, 32'h0C);
        clk_en <= 1'b0;
        pulse(6'h01);
        clk_en <= 1'b1;
        rc(8'h04, 32'h0C);
    endtask
    // Chip reset clears permission only; user write refused
    task t_chip;
        chip_rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chip_rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0C);
        chk(stop_permitted, 32'h0);
        pulse(6'h04);
        chk(power_mode_status, 32'h01);
        bus(1'b1, 4'h1, 8'h00, 32'h2A);
        chk(rsp, 32'h1);
        rc(8'h00, 32'h0);
        wr(8'h00, 32'h20);
        chk(rsp, 32'h0);
        rc(8'h00, 32'h20);
        rc(8'h04, 32'h08);
        chk(stop_permitted, 32'h1);
    endtask

    task end_sim;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset;
        t_refuse;
        t_permit;
        t_run;
        t_stop;
        t_abort;
        t_chip;
        end_sim;
    end
    // Hang guard, far beyond the under two hundred cycles needed
    initial begin
        #200000;
        errors++;
        end_sim;
    end
endmodule
